// ==== rtl/cls_pkg.sv ====
// Constants, field layouts and carrier types for the clock-loss interrupt block
// Functional notes
// - Device interrupt asserts only while global enable and combined status are both one.
// - Combined status is OR of each source flag ANDed with its enable; read-only.
// - Crystal loss flag reaches the combined status only while its enable is one.
// - Crystal loss interrupt flag always mirrors the sticky loss event bit; read-only.
// - Reference-invalid reads one when any monitor disqualifies the clock; resets to one.
// - Live loss status shows current monitor result, one on loss; resets to one.
// - Sticky loss event sets whenever monitor reports loss, held while loss lasts.
// - Writing one clears the event unless loss persists; writing zero does nothing.
// - Event bit sets on leaving reset; software clears it after configuring monitor.
// - Set event keeps reporting past loss after live status returns to zero.
// - Failure mask zero lets live loss feed reference-invalid; one blocks it.
package cls_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [7:0] OFF_INT_EN = 8'h00;
    localparam logic [7:0] OFF_INT_STS = 8'h04;
    localparam logic [7:0] OFF_LOSS_STS = 8'h08;
    localparam logic [7:0] OFF_LOSS_EVT = 8'h0c;
    localparam logic [7:0] OFF_MON_CTL = 8'h10;
    localparam int DEC_W = 8;

    // Field positions
    localparam int BIT_DEV_EN = 15;
    localparam int BIT_XTAL_EN = 6;
    localparam int RSV_EN_LSB = 9;
    localparam int RSV_EN_W = 3;
    localparam int BIT_DEV_STS = 15;
    localparam int BIT_XTAL_STS = 6;
    localparam int BIT_REF_INV = 1;
    localparam int BIT_LOSS = 0;
    localparam int BIT_EVT = 0;
    localparam int BIT_SOFT_RST = 0;
    localparam int BIT_FAIL_MASK = 1;
    localparam int PIN_SEL_LSB = 2;

    // Status pin sources
    localparam logic [1:0] PIN_SRC_LOCK = 2'h0;
    localparam logic [1:0] PIN_SRC_IRQ = 2'h1;
    localparam logic [1:0] PIN_SRC_REF_INV = 2'h2;
    localparam logic [1:0] PIN_SRC_LOW = 2'h3;

    // Reset values
    localparam logic LOSS_RST = 1'b1;
    localparam logic REF_INV_RST = 1'b1;
    localparam logic EVT_RST = 1'b1;
    localparam logic [RSV_EN_W-1:0] RSV_EN_RST = 3'h0;

    // AHB-Lite codes
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // Software control fields
    typedef struct packed {
        logic [1:0] pin_sel;
        logic fail_mask;
        logic soft_reset;
    } cls_ctrl_t;

    localparam cls_ctrl_t CTRL_RST = '{pin_sel: PIN_SRC_LOCK, fail_mask: 1'b0, soft_reset: 1'b0};

    // Interrupt enable fields
    typedef struct packed {
        logic dev_en;
        logic [RSV_EN_W-1:0] rsv;
        logic xtal_loss_irq_enable;
    } cls_int_en_t;

    localparam cls_int_en_t INT_EN_RST = '{dev_en: 1'b0, rsv: RSV_EN_RST, xtal_loss_irq_enable: 1'b0};

    // Monitor state seen by software
    typedef struct packed {
        logic ref_invalid;
        logic loss_live;
        logic loss_event;
    } cls_mon_t;

    // Bus data-phase states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WRITE,
        ST_RD_WAIT,
        ST_RD_DONE
    } cls_bus_state_t;

endpackage

// ==== rtl/cls_sync.sv ====
// Two-stage synchroniser for monitor inputs from outside the system clock
`timescale 1ns/1ps
`default_nettype none
module cls_sync
    import cls_pkg::*;
#(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("cls_sync needs WIDTH of at least one");
        end
    endgenerate

    // First stage is read only by the second
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule
`default_nettype wire

// ==== rtl/cls_top.sv ====
// Clock-loss monitor status, sticky event and interrupt logic with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
module cls_top
    import cls_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Monitor and lock inputs, asynchronous to ref_clk
    input wire logic loss_detect,
    input wire logic activity_fail,
    input wire logic pll_lock,
    // Outputs
    output logic irq,
    output logic status_pin,
    output logic monitor_soft_reset
);

    // Data word width as seen on the bus
    localparam int DATA_W = $bits(hwdata);

    // Elaboration checks on the address width and the field layout
    generate
        if (ADDR_W < DEC_W) begin : g_bad_addr
            $error("cls_top needs ADDR_W of at least eight");
        end
        // A field placed beyond the word would silently vanish from reads
        if (BIT_DEV_EN >= DATA_W || BIT_DEV_STS >= DATA_W) begin : g_bad_top_bit
            $error("cls_top global enable or combined status lies outside the data word");
        end
        if (RSV_EN_LSB + RSV_EN_W > BIT_DEV_EN) begin : g_bad_rsv
            $error("cls_top reserved enable bits overlap the global enable");
        end
        if (BIT_XTAL_EN >= RSV_EN_LSB) begin : g_bad_src_bit
            $error("cls_top source enable overlaps the reserved enable bits");
        end
        if (BIT_FAIL_MASK == BIT_SOFT_RST || PIN_SEL_LSB <= BIT_FAIL_MASK) begin : g_bad_ctrl
            $error("cls_top control fields overlap");
        end
    endgenerate

    // Address match: upper bits zero, low byte equal, word aligned
    function automatic logic addr_is(
        input logic [ADDR_W-1:0] a,
        input logic [DEC_W-1:0] off
    );
        logic upper_zero;
        upper_zero = (a >> DEC_W) == '0;
        return upper_zero && (a[DEC_W-1:0] == off);
    endfunction

    // Set-wins sticky update shared by the event flag
    // A clear can never hide an event that is still being reported
    function automatic logic sticky_next(
        input logic cur,
        input logic set,
        input logic clr
    );
        return set | (cur & ~clr);
    endfunction

    // Input synchronisation
    // Monitor and lock pins are levels from other clock domains
    logic [2:0] raw_in;
    logic [2:0] sync_in;
    logic loss_sync;
    logic act_sync;
    logic lock_sync;

    // Bit order fixed by the synchroniser reset value below
    assign raw_in = {pll_lock, activity_fail, loss_detect};

    // Reset to loss asserted so nothing looks valid before real samples
    // Lock and activity reset low, matching the register reset view
    cls_sync #(
        .WIDTH(3),
        .RST_VAL({1'b0, 1'b0, LOSS_RST})
    ) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in(raw_in),
        .sync_out(sync_in)
    );

    assign loss_sync = sync_in[0];
    assign act_sync = sync_in[1];
    assign lock_sync = sync_in[2];

    // Bus front end
    // One slave, single word transfers, reads take one wait state
    cls_bus_state_t state;
    cls_bus_state_t next_state;
    logic [ADDR_W-1:0] dp_addr;
    logic addr_take;
    logic wr_take;
    logic rd_take;

    // Address phase accepted only when the previous transfer has ended
    assign addr_take = hsel && htrans[1] && hready;
    assign wr_take = addr_take && hwrite;
    assign rd_take = addr_take && !hwrite;

    // Reads spend one wait cycle so read data comes from a flop
    // and already sees a write that ended at the address edge
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE,
            ST_WRITE,
            ST_RD_DONE: begin
                if (wr_take) begin
                    next_state = ST_WRITE;
                end else if (rd_take) begin
                    next_state = ST_RD_WAIT;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_RD_WAIT: begin
                next_state = ST_RD_DONE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Only the read wait cycle stretches the bus
    assign hreadyout = (state != ST_RD_WAIT);
    // No error response: unmapped and read-only writes just complete
    assign hresp = 1'b0;

    // Data-phase state and latched address
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            dp_addr <= '0;
        end else begin
            state <= next_state;
            if (addr_take) begin
                dp_addr <= haddr;
            end
        end
    end

    // Register hits on the latched data-phase address
    logic hit_int_en;
    logic hit_int_sts;
    logic hit_loss_sts;
    logic hit_loss_evt;
    logic hit_mon_ctl;

    assign hit_int_en = addr_is(dp_addr, OFF_INT_EN);
    assign hit_int_sts = addr_is(dp_addr, OFF_INT_STS);
    assign hit_loss_sts = addr_is(dp_addr, OFF_LOSS_STS);
    assign hit_loss_evt = addr_is(dp_addr, OFF_LOSS_EVT);
    assign hit_mon_ctl = addr_is(dp_addr, OFF_MON_CTL);

    // Write strobes in the data phase; read-only and unmapped hits fall away
    logic wr_phase;
    logic wr_int_en;
    logic wr_loss_evt;
    logic wr_mon_ctl;

    assign wr_phase = (state == ST_WRITE);
    assign wr_int_en = wr_phase && hit_int_en;
    assign wr_loss_evt = wr_phase && hit_loss_evt;
    assign wr_mon_ctl = wr_phase && hit_mon_ctl;

    // Software registers
    // Written in the data phase, so a read right after sees the new value
    cls_int_en_t int_en;
    cls_ctrl_t ctrl;

    // Enables; reserved writable bits just store and read back
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            int_en <= INT_EN_RST;
        end else if (wr_int_en) begin
            int_en.dev_en <= hwdata[BIT_DEV_EN];
            int_en.rsv <= hwdata[RSV_EN_LSB +: RSV_EN_W];
            int_en.xtal_loss_irq_enable <= hwdata[BIT_XTAL_EN];
        end
    end

    // Monitor control: soft reset, failure mask and pin source
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl <= CTRL_RST;
        end else if (wr_mon_ctl) begin
            ctrl.soft_reset <= hwdata[BIT_SOFT_RST];
            ctrl.fail_mask <= hwdata[BIT_FAIL_MASK];
            ctrl.pin_sel <= hwdata[PIN_SEL_LSB +: $bits(ctrl.pin_sel)];
        end
    end

    // Software is expected to hold this while rewriting monitor setup
    assign monitor_soft_reset = ctrl.soft_reset;

    // Monitor status and sticky event
    // All three flags run from synchronised inputs only
    cls_mon_t mon;
    logic next_loss_live;
    logic next_ref_invalid;
    logic next_loss_event;
    logic evt_clear;

    // Soft reset forces the reset view: loss seen, clock invalid
    assign next_loss_live = ctrl.soft_reset ? LOSS_RST : loss_sync;
    // Mask blocks only the loss term; activity failure always counts
    assign next_ref_invalid = ctrl.soft_reset ? REF_INV_RST
        : ((mon.loss_live & ~ctrl.fail_mask) | act_sync);

    // Write of one clears, write of zero leaves it alone
    assign evt_clear = wr_loss_evt && hwdata[BIT_EVT];
    // Live loss and soft reset both set; set wins over a clear in the same cycle
    assign next_loss_event = sticky_next(mon.loss_event,
        mon.loss_live | ctrl.soft_reset, evt_clear);

    // Event comes out of reset set, needing a clear once configured
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mon.loss_live <= LOSS_RST;
            mon.ref_invalid <= REF_INV_RST;
            mon.loss_event <= EVT_RST;
        end else begin
            mon.loss_live <= next_loss_live;
            mon.ref_invalid <= next_ref_invalid;
            mon.loss_event <= next_loss_event;
        end
    end

    // Interrupt aggregation
    // Global enable gates the interrupt but not the readable combined bit
    logic xtal_loss_irq_flag;
    logic xtal_gated;
    logic dev_int_sts;
    logic dev_int;

    // Flag is a plain mirror, no storage of its own
    assign xtal_loss_irq_flag = mon.loss_event;
    assign xtal_gated = xtal_loss_irq_flag & int_en.xtal_loss_irq_enable;
    // Only one source today; more would OR in here
    assign dev_int_sts = xtal_gated;
    assign dev_int = dev_int_sts & int_en.dev_en;

    // Level output from flops only, so it falls right after a clear edge
    assign irq = dev_int;

    // Status pin
    // One shared output, its source chosen by software
    logic pin_is_irq;
    logic pin_is_lock;
    logic pin_is_ref_inv;
    logic next_status_pin;

    // Source decode; the spare code drives the pin low
    assign pin_is_irq = (ctrl.pin_sel == PIN_SRC_IRQ);
    assign pin_is_lock = (ctrl.pin_sel == PIN_SRC_LOCK);
    assign pin_is_ref_inv = (ctrl.pin_sel == PIN_SRC_REF_INV);

    // Pin carries the enable-gated interrupt, never the raw combined status
    assign next_status_pin =
        pin_is_irq ? dev_int :
        pin_is_lock ? lock_sync :
        pin_is_ref_inv ? mon.ref_invalid :
        1'b0;

    // Registered to keep the pin glitch free, one cycle behind its source
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            status_pin <= 1'b0;
        end else begin
            status_pin <= next_status_pin;
        end
    end

    // Read path
    // Reserved enable bits read back what was last written
    logic [31:0] rd_int_en;
    logic [31:0] rd_int_sts;
    logic [31:0] rd_loss_sts;
    logic [31:0] rd_loss_evt;
    logic [31:0] rd_mon_ctl;
    logic [31:0] rd_word;

    // Word images; unlisted bits read as zero
    always_comb begin
        rd_int_en = RDATA_ZERO;
        rd_int_en[BIT_DEV_EN] = int_en.dev_en;
        rd_int_en[RSV_EN_LSB +: RSV_EN_W] = int_en.rsv;
        rd_int_en[BIT_XTAL_EN] = int_en.xtal_loss_irq_enable;
        rd_int_sts = RDATA_ZERO;
        rd_int_sts[BIT_DEV_STS] = dev_int_sts;
        rd_int_sts[BIT_XTAL_STS] = xtal_loss_irq_flag;
        rd_loss_sts = RDATA_ZERO;
        rd_loss_sts[BIT_REF_INV] = mon.ref_invalid;
        rd_loss_sts[BIT_LOSS] = mon.loss_live;
        rd_loss_evt = RDATA_ZERO;
        rd_loss_evt[BIT_EVT] = mon.loss_event;
        rd_mon_ctl = RDATA_ZERO;
        rd_mon_ctl[BIT_SOFT_RST] = ctrl.soft_reset;
        rd_mon_ctl[BIT_FAIL_MASK] = ctrl.fail_mask;
        rd_mon_ctl[PIN_SEL_LSB +: 2] = ctrl.pin_sel;
    end

    // Address select; unmapped reads give zero
    assign rd_word =
        hit_int_en ? rd_int_en :
        hit_int_sts ? rd_int_sts :
        hit_loss_sts ? rd_loss_sts :
        hit_loss_evt ? rd_loss_evt :
        hit_mon_ctl ? rd_mon_ctl :
        RDATA_ZERO;

    // Read data is loaded only in the wait cycle of a read
    logic rd_load;

    assign rd_load = (state == ST_RD_WAIT);

    // Captured in the wait cycle, held until the next read
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hrdata <= RDATA_ZERO;
        end else if (rd_load) begin
            hrdata <= rd_word;
        end
    end

    // Size is accepted as is; only word transfers are expected
    // A narrower write would still update the whole register
    logic unused_ok;
    assign unused_ok = ^{hsize, htrans[0]};

endmodule
`default_nettype wire

// ==== sim/cls_host.sv ====
// Host model that masters single AHB-Lite word transfers
`timescale 1ns/1ps
`default_nettype none
module cls_host
    import cls_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    input wire logic ref_clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [ADDR_W-1:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // Bus idle from time zero so reset sees no request
    initial begin
        hsel = 1'b0;
        haddr = '0;
        htrans = HTRANS_IDLE;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // One transfer; waits on hready with no assumed latency
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {{(ADDR_W-8){1'b0}}, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= HTRANS_IDLE;
        hwdata <= d;
        do @(posedge ref_clk); while (hready !== 1'b1);
        r = hrdata;
    endtask
endmodule
`default_nettype wire

// ==== sim/cls_top_props.sv ====
// Port-level assertions for the clock-loss interrupt block
`timescale 1ns/1ps
`default_nettype none
module cls_top_props
    import cls_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic loss_detect,
    input wire logic irq,
    input wire logic status_pin
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic wr_dp;
    logic [7:0] wa;
    logic dev_en;
    logic xen;
    logic [1:0] psel;
    logic srst;
    wire take = hsel && htrans[1] && hready;
    wire wr_end = wr_dp && hready;
    wire en_wr = wr_end && (wa == OFF_INT_EN || wa == OFF_LOSS_EVT);
    wire clr_end = wr_end && wa == OFF_LOSS_EVT && hwdata[BIT_EVT];

    // Shadow of enables and pin source, same edge as the real registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_dp <= 1'b0;
            wa <= 8'h00;
            dev_en <= 1'b0;
            xen <= 1'b0;
            psel <= PIN_SRC_LOCK;
            srst <= 1'b0;
        end else begin
            if (hready) wr_dp <= take && hwrite;
            if (take) wa <= haddr[7:0];
            if (wr_end && wa == OFF_INT_EN) dev_en <= hwdata[BIT_DEV_EN];
            if (wr_end && wa == OFF_INT_EN) xen <= hwdata[BIT_XTAL_EN];
            if (wr_end && wa == OFF_MON_CTL) psel <= hwdata[PIN_SEL_LSB+1:PIN_SEL_LSB];
            if (wr_end && wa == OFF_MON_CTL) srst <= hwdata[BIT_SOFT_RST];
        end
    end

    chk_irq_global: assert property (!dev_en |-> !irq)
        else $error("irq high with global enable off");
    chk_irq_source: assert property (!xen |-> !irq)
        else $error("irq high with crystal loss enable off");
    chk_pin_irq: assert property ((psel == PIN_SRC_IRQ)[*2] |-> status_pin == $past(irq))
        else $error("status pin does not follow interrupt");
    chk_enable_drop: assert property ($fell(xen) || $fell(dev_en) |-> !irq)
        else $error("irq stayed after enable removed");
    chk_loss_sets: assert property ((loss_detect && dev_en && xen)[*6] |-> irq)
        else $error("loss did not raise irq");
    chk_event_sticky: assert property (irq && !en_wr |=> irq)
        else $error("irq dropped without clear");
    chk_clear_drop: assert property ((!loss_detect && !srst)[*4] ##0 clr_end |=> !irq)
        else $error("irq stayed after event clear");
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("response not OKAY");
    chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    chk_write_nowait: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
endmodule

bind cls_top cls_top_props #(.ADDR_W(ADDR_W)) u_props (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .loss_detect(loss_detect), .irq(irq), .status_pin(status_pin));
`default_nettype wire

// ==== sim/cls_top_tb_top.sv ====
// Self-checking bench for the clock-loss interrupt block
`timescale 1ns/1ps
`default_nettype none
module cls_top_tb_top
    import cls_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic loss_detect = 1'b1;
    logic activity_fail = 1'b0;
    logic pll_lock = 1'b0;
    wire hsel;
    wire [31:0] haddr;
    wire [1:0] htrans;
    wire hwrite;
    wire [2:0] hsize;
    wire [31:0] hwdata;
    wire hreadyout;
    wire hresp;
    wire [31:0] hrdata;
    wire irq;
    wire status_pin;
    wire monitor_soft_reset;
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [31:0] seed = 32'hbfb14837;

    always #50 ref_clk = ~ref_clk;

    cls_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .loss_detect(loss_detect), .activity_fail(activity_fail),
        .pll_lock(pll_lock), .irq(irq), .status_pin(status_pin), .monitor_soft_reset(monitor_soft_reset));
    cls_host host (.ref_clk(ref_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    // Repeatable pseudo-random source
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    // Expected status pin for a given source
    function automatic logic exp_pin(input logic [1:0] s, input logic lk, input logic iq, input logic ri);
        return s == PIN_SRC_LOCK ? lk : s == PIN_SRC_IRQ ? iq : s == PIN_SRC_REF_INV ? ri : 1'b0;
    endfunction

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        host.xfer(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        host.xfer(1'b1, a, d, r);
    endtask

    // Long enough for synchroniser, event and pin stages to settle
    task automatic settle();
        repeat (8) @(posedge ref_clk);
    endtask

    // Hang guard, well above the expected run length
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            errors++;
            summarize();
        end
    end

    initial begin
        logic l, m, a, lk, de, xe;
        logic [1:0] ps;
        logic [2:0] rv;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd(OFF_INT_EN, 32'h0);
        rd(OFF_INT_STS, 32'h40);
        rd(OFF_LOSS_STS, 32'h3);
        rd(OFF_LOSS_EVT, 32'h1);
        rd(8'h14, 32'h0);
        wr(OFF_INT_STS, 32'hffff_ffff);
        rd(OFF_INT_STS, 32'h40);
        // Configure under soft reset, then release
        wr(OFF_MON_CTL, 32'h5);
        @(posedge ref_clk);
        chk({31'h0, monitor_soft_reset}, 32'h1);
        rv = seed[2:0];
        wr(OFF_INT_EN, 32'h8040 | {rv, 9'h0});
        rd(OFF_INT_EN, 32'h8040 | {rv, 9'h0});
        wr(OFF_MON_CTL, 32'h4);
        @(posedge ref_clk);
        chk({31'h0, monitor_soft_reset}, 32'h0);
        loss_detect <= 1'b0;
        settle();
        rd(OFF_LOSS_STS, 32'h0);
        chk({31'h0, irq}, 32'h1);
        wr(OFF_LOSS_EVT, 32'h0);
        rd(OFF_LOSS_EVT, 32'h1);
        wr(OFF_LOSS_EVT, 32'h1);
        @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0);
        // Random loss, mask, enables and pin source
        repeat (24) begin
            seed = xs(seed);
            {ps, xe, de, lk, a, m, l} = seed[7:0];
            @(posedge ref_clk);
            loss_detect <= l;
            activity_fail <= a;
            pll_lock <= lk;
            wr(OFF_MON_CTL, {28'h0, ps, m, 1'b0});
            wr(OFF_INT_EN, {16'h0, de, 8'h0, xe, 6'h0});
            settle();
            wr(OFF_LOSS_EVT, 32'h1);
            settle();
            rd(OFF_LOSS_STS, {30'h0, (l & ~m) | a, l});
            rd(OFF_LOSS_EVT, {31'h0, l});
            rd(OFF_INT_STS, {16'h0, l & xe, 8'h0, l, 6'h0});
            chk({31'h0, irq}, {31'h0, l & xe & de});
            chk({31'h0, status_pin}, {31'h0, exp_pin(ps, lk, l & xe & de, (l & ~m) | a)});
            @(posedge ref_clk);
            loss_detect <= 1'b0;
            settle();
            rd(OFF_LOSS_EVT, {31'h0, l});
        end
        summarize();
    end
endmodule
`default_nettype wire
